/* File: csd_defs.svh */
// Constants for the chip select decoder: timing, field positions, resets
`ifndef CSD_DEFS_SVH
`define CSD_DEFS_SVH

// ============================================================
// Geometry
`define CSD_NUM_SEL        8
`define CSD_NUM_MUX        4
`define CSD_MUX_FIRST      4
`define CSD_BASE_HI        31
`define CSD_BASE_LO        12
`define CSD_SIZE_W         4
`define CSD_SIZE_MAX       4'hc
`define CSD_WAIT_W         4

// ============================================================
// Timing
`define CSD_CLK_NS         8
`define CSD_MAX_ACCESS_NS  950
`define CSD_MAX_ACCESS_CYC (`CSD_MAX_ACCESS_NS / `CSD_CLK_NS)
`define CSD_WAIT_UNIT_CYC  8
// Strap counter value at which the synchronised mode is taken
`define CSD_STRAP_TAKE     2'h2

// ============================================================
// Reset values
`define CSD_RST_BASE       20'h00000
`define CSD_RST_SIZE       4'h0
`define CSD_RST_WAIT       4'hf

`endif

/* File: csd_pkg.sv */
// Types shared by the chip select decoder files
package csd_pkg;
  typedef enum logic [1:0] {
    CSD_IDLE = 2'b00,
    CSD_WAIT = 2'b01,
    CSD_ACK  = 2'b11,
    CSD_DONE = 2'b10
  } csd_state_t;
endpackage : csd_pkg

/* File: csd_cfg_mem.sv */
// Per-select configuration store: base, range and cycle duration
`timescale 1ns/1ps
`include "csd_defs.svh"

module csd_cfg_mem
  import csd_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        wrEn,
  input  wire logic [2:0]  wrSel,
  input  wire logic [19:0] wrBase,
  input  wire logic [3:0]  wrSize,
  input  wire logic [3:0]  wrWait,
  output logic      [159:0] baseFlat,
  output logic      [31:0]  sizeFlat,
  output logic      [31:0]  waitFlat
);

  logic [159:0] baseFlat_d;
  logic [31:0]  sizeFlat_d;
  logic [31:0]  waitFlat_d;

  // ============================================================
  // Write port
  always_comb begin
    baseFlat_d = baseFlat;
    sizeFlat_d = sizeFlat;
    waitFlat_d = waitFlat;
    if (wrEn) begin
      baseFlat_d[wrSel*20 +: 20] = wrBase;
      sizeFlat_d[wrSel*4 +: 4]   = wrSize;
      waitFlat_d[wrSel*4 +: 4]   = wrWait;
    end
  end

  // Registered storage; read data come straight from these flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      baseFlat <= {8{`CSD_RST_BASE}};
      sizeFlat <= {8{`CSD_RST_SIZE}};
      waitFlat <= {8{`CSD_RST_WAIT}};
    end else begin
      baseFlat <= baseFlat_d;
      sizeFlat <= sizeFlat_d;
      waitFlat <= waitFlat_d;
    end
  end

endmodule : csd_cfg_mem

/* File: csd_chip_select.sv */
// Chip select decoder: address windows, bus handshake, pin mode strap
`timescale 1ns/1ps
`include "csd_defs.svh"

module csd_chip_select
  import csd_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic [31:0] busAddr,
  input  wire logic        busStrobe,
  input  wire logic        cfgWrEn,
  input  wire logic [2:0]  cfgSel,
  input  wire logic [19:0] cfgBase,
  input  wire logic [3:0]  cfgSize,
  input  wire logic [3:0]  cfgWait,
  input  wire logic        cfgDone,
  input  wire logic        pinFunctionModeInput,
  output logic      [7:0]  selectOut_b,
  output logic      [3:0]  upperAddressLines,
  output logic      [3:0]  upperPinOut,
  output logic             busAck_b,
  output logic             pinModeIsAddr,
  output logic             configuredFlag
);

  logic [159:0] baseFlat;
  logic [31:0]  sizeFlat;
  logic [31:0]  waitFlat;
  logic [7:0]   hit;
  logic [7:0]   hitRaw;
  logic [2:0]   winSel;
  logic         anyHit;

  csd_state_t   state_q, state_d;
  logic [6:0]   cnt_q, cnt_d;
  logic [7:0]   selectOut_d;
  logic         busAck_d;
  logic [3:0]   upperPinOut_d;
  logic [3:0]   upperAddressLines_d;
  logic         configured_q, configured_d;
  logic         modeSync1_q, modeSync2_q;
  logic         modeHeld_q, modeHeld_d;
  logic [1:0]   strapCnt_q, strapCnt_d;

  // ============================================================
  // Configuration store
  // per-select registers
  csd_cfg_mem u_cfg (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .wrEn     (cfgWrEn),
    .wrSel    (cfgSel),
    .wrBase   (cfgBase),
    .wrSize   (cfgSize),
    .wrWait   (cfgWait),
    .baseFlat (baseFlat),
    .sizeFlat (sizeFlat),
    .waitFlat (waitFlat)
  );

  // ============================================================
  // Address windows, one per select
  genvar g;
  generate
    for (g = 0; g < `CSD_NUM_SEL; g++) begin : g_win
      // Base bits below the window are ignored, so align the base
      logic [3:0]  sz;
      logic [31:0] mask;
      // window 4 KB << size, capped at 16 MB
      assign sz = (sizeFlat[g*4 +: 4] > `CSD_SIZE_MAX) ?
                  `CSD_SIZE_MAX : sizeFlat[g*4 +: 4];
      assign mask = 32'hffffffff << (5'(sz) + 5'd12);
      assign hitRaw[g] = ((busAddr & mask) ==
                          ({baseFlat[g*20 +: 20], 12'h000} & mask));
    end
  endgenerate

  // before programming, select zero catches every access
  assign hit = configured_q ? hitRaw : 8'h01;

  // Lowest numbered select wins when windows overlap
  always_comb begin
    winSel = 3'h0;
    anyHit = 1'b0;
    for (int i = `CSD_NUM_SEL - 1; i >= 0; i--) begin
      if (hit[i]) begin
        winSel = 3'(i);
        anyHit = 1'b1;
      end
    end
  end

  // ============================================================
  // Mode strap: two-flop synchroniser, then one capture after release
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      modeSync1_q <= 1'b0;
      modeSync2_q <= 1'b0;
    end else begin
      modeSync1_q <= pinFunctionModeInput;
      modeSync2_q <= modeSync1_q;
    end
  end

  // capture once, third edge after release
  // later pin changes ignored until next reset
  always_comb begin
    // Saturating edge count, so the capture fires only once
    strapCnt_d = (strapCnt_q == 2'h3) ? strapCnt_q : strapCnt_q + 2'h1;
    modeHeld_d = (strapCnt_q == `CSD_STRAP_TAKE) ? modeSync2_q : modeHeld_q;
  end

  // Sync delay means the pin must hold one cycle past release; its level at the first edge is the one taken
  // Limitation: a strap that moves in that time may be caught mid-way
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      strapCnt_q <= 2'h0;
      modeHeld_q <= 1'b0;
    end else begin
      strapCnt_q <= strapCnt_d;
      modeHeld_q <= modeHeld_d;
    end
  end

  // ============================================================
  // Cycle sequencer
  always_comb begin
    state_d      = state_q;
    cnt_d        = cnt_q;
    configured_d = configured_q | cfgDone;
    selectOut_d  = selectOut_b;
    busAck_d     = 1'b1;
    // Outputs are registered, so each decision shows one edge later
    case (state_q)
      CSD_IDLE: begin
        selectOut_d = 8'hff;
        // A miss gets no ack; the bus watchdog ends it
        if (busStrobe && anyHit) begin
          selectOut_d = ~(8'h01 << winSel);
          // wait units of 8 cycles, capped at 950 ns
          cnt_d = (7'(waitFlat[winSel*4 +: 4]) * 7'(`CSD_WAIT_UNIT_CYC)
                   > 7'(`CSD_MAX_ACCESS_CYC)) ?
                  7'(`CSD_MAX_ACCESS_CYC) :
                  7'(waitFlat[winSel*4 +: 4]) * 7'(`CSD_WAIT_UNIT_CYC);
          state_d = CSD_WAIT;
        end
      end
      CSD_WAIT: begin
        if (cnt_q == 7'h00) begin
          busAck_d = 1'b0;
          state_d  = CSD_ACK;
        end else begin
          // Strobe not watched here; host holds it until ack
          cnt_d = cnt_q - 7'h01;
        end
      end
      CSD_ACK: begin
        busAck_d = 1'b0;
        if (!busStrobe) begin
          busAck_d    = 1'b1;
          selectOut_d = 8'hff;
          state_d     = CSD_DONE;
        end
      end
      CSD_DONE: begin
        // Dead cycle, so a strobe still high is not taken twice
        state_d = CSD_IDLE;
      end
      default: begin
        // Unused code: drop every select and restart
        state_d     = CSD_IDLE;
        selectOut_d = 8'hff;
      end
    endcase
  end

  // upper pins carry selects 7..4 or address 23..20
  always_comb begin
    upperAddressLines_d = busAddr[23:20];
    upperPinOut_d = modeHeld_q ? busAddr[23:20] : selectOut_d[7:4];
  end

  // Registered outputs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q           <= CSD_IDLE;
      cnt_q             <= 7'h00;
      configured_q      <= 1'b0;
      selectOut_b       <= 8'hff;
      busAck_b          <= 1'b1;
      upperPinOut       <= 4'hf;
      upperAddressLines <= 4'h0;
    end else begin
      state_q           <= state_d;
      cnt_q             <= cnt_d;
      configured_q      <= configured_d;
      selectOut_b       <= selectOut_d;
      busAck_b          <= busAck_d;
      upperPinOut       <= upperPinOut_d;
      upperAddressLines <= upperAddressLines_d;
    end
  end

  // Status outputs are flop outputs, no logic after them
  assign pinModeIsAddr  = modeHeld_q;
  assign configuredFlag = configured_q;

endmodule : csd_chip_select

/* File: csd_chip_select_asserts.sv */
// Port checker for the chip select decoder
`timescale 1ns/1ps
module csd_chip_select_asserts (
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       busStrobe,
  input wire logic [7:0] selectOut_b,
  input wire logic [3:0] upperAddressLines,
  input wire logic [3:0] upperPinOut,
  input wire logic       busAck_b,
  input wire logic       pinModeIsAddr,
  input wire logic       configuredFlag
);
  // ==========
  // Helpers
  logic [2:0] relCnt_q;
  logic [2:0] relCnt_d;
  logic       anySel;
  // Skips the strap capture window
  assign relCnt_d = (relCnt_q == 3'h7) ? relCnt_q : relCnt_q + 3'h1;
  assign anySel = selectOut_b != 8'hff;
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b) relCnt_q <= 3'h0;
    else relCnt_q <= relCnt_d;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence selStart; $rose(anySel); endsequence
  // ==========
  // Assertions
  // at most one low
  a_one_select: assert property ($onehot0(~selectOut_b))
    else $error("several selects");
  a_release_next: assert property (!busStrobe |=> !anySel && busAck_b)
    else $error("no release");
  a_ack_bound: assert property (selStart |-> ##[1:119] !busAck_b)
    else $error("late ack");
  a_ack_cause: assert property ($fell(busAck_b) |-> $past(anySel))
    else $error("ack alone");
  a_ack_holds: assert property (!busAck_b && busStrobe |=> !busAck_b)
    else $error("ack dropped");
  a_boot_zero: assert property (!configuredFlag && anySel |->
    selectOut_b == 8'hfe) else $error("boot select");
  a_mode_fixed: assert property (relCnt_q > 3'h4 |->
    $stable(pinModeIsAddr)) else $error("mode moved");
  a_pin_mux: assert property (relCnt_q > 3'h4 |-> upperPinOut ==
    (pinModeIsAddr ? upperAddressLines : selectOut_b[7:4]))
    else $error("pin mux");
endmodule : csd_chip_select_asserts

bind csd_chip_select csd_chip_select_asserts u_chk (.core_clk, .rst_b,
  .busStrobe, .selectOut_b, .upperAddressLines, .upperPinOut, .busAck_b,
  .pinModeIsAddr, .configuredFlag);

/* File: csd_strap_model.sv */
// Mode strap source holding its level across reset release
`timescale 1ns/1ps
module csd_strap_model (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic modeReq,
  output logic      strapOut
);
  // ==========
  // Strap
  logic [2:0] cnt_q;
  logic       held;
  always_latch if (!rst_b) held <= modeReq;
  always_ff @(posedge core_clk or negedge rst_b)
    if (!rst_b) cnt_q <= 3'h0;
    else if (cnt_q != 3'h7) cnt_q <= cnt_q + 3'h1;
  assign strapOut = (cnt_q < 3'h5) ? held : modeReq;
endmodule : csd_strap_model

/* File: csd_chip_select_tb.sv */
// Self-checking bench for the chip select decoder
`timescale 1ns/1ps
module csd_chip_select_tb;
  logic        core_clk = 0, rst_b = 0, busStrobe = 0, cfgWrEn = 0;
  logic        cfgDone = 0, modeReq = 0, strap, busAck_b, pinModeIsAddr;
  logic        configuredFlag, done;
  logic [31:0] busAddr = 0, a;
  logic [19:0] cfgBase = 0, baseA [8];
  logic [3:0]  cfgSize = 0, cfgWait = 0, upperAddressLines, upperPinOut;
  logic [3:0]  sizeA [8], waitA [8];
  logic [2:0]  cfgSel = 0;
  logic [7:0]  selectOut_b, s;
  int          n_fail = 0, comparisons = 0, n, e, m;
  // ==========
  // Harness
  csd_chip_select DUT (.core_clk, .rst_b, .busAddr, .busStrobe, .cfgWrEn,
    .cfgSel, .cfgBase, .cfgSize, .cfgWait, .cfgDone,
    .pinFunctionModeInput(strap), .selectOut_b, .upperAddressLines,
    .upperPinOut, .busAck_b, .pinModeIsAddr, .configuredFlag);
  csd_strap_model STRAP (.core_clk, .rst_b, .modeReq, .strapOut(strap));
  initial forever #4 core_clk = ~core_clk;
  task automatic give_verdict;
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task automatic check(logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  // Unprogrammed unit maps all to select zero; 8 means miss
  function automatic int expIdx(logic [31:0] x);
    for (int i = 0; i < 8; i++)
      if (!done || (x >> 12) - baseA[i] < (32'h1 << (i == 7 ? 12 : sizeA[i])))
        return i;
    return 8;
  endfunction : expIdx
  // One strobed access, held until ack or bound
  task automatic access(logic [31:0] x);
    e = expIdx(x);
    s = 8'hff ^ (8'h1 << e);
    @(negedge core_clk);
    busAddr = x;
    busStrobe = 1;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (busAck_b && n < 130);
    if (e < 8) begin
      if (busAck_b) begin
        check(busAck_b, 0);
        give_verdict;
      end
      check(n, (waitA[e] > 14 ? 118 : waitA[e] * 8) + 2);
    end else check(busAck_b, 1);
    check(selectOut_b, s);
    check(upperPinOut, m ? x[23:20] : s[7:4]);
    check(upperAddressLines, x[23:20]);
    check(pinModeIsAddr, m);
    busStrobe = 0;
    repeat (3) @(negedge core_clk);
    check(selectOut_b, 8'hff);
    check(busAck_b, 1);
  endtask : access
  // ==========
  // Sequence
  initial begin
    a = $urandom(59);
    for (m = 0; m < 2; m++) begin
      rst_b = 0;
      modeReq = m[0];
      done = 0;
      waitA[0] = 4'hf;
      repeat (3) @(negedge core_clk);
      rst_b = 1;
      repeat (5) @(negedge core_clk);
      modeReq = !m[0];
      @(negedge core_clk);
      check(pinModeIsAddr, m);
      check(configuredFlag, 0);
      access($urandom);
      for (int i = 0; i < 8; i++) begin
        baseA[i] = {i[2:0], 5'($urandom), 12'h0};
        sizeA[i] = (i == 7) ? 4'hf : 4'($urandom_range(12));
        waitA[i] = (i == 0) ? 4'h0 : (i == 7) ? 4'hf : 4'($urandom);
        @(negedge core_clk);
        cfgWrEn = 1;
        cfgSel = i[2:0];
        cfgBase = baseA[i];
        cfgSize = sizeA[i];
        cfgWait = waitA[i];
      end
      @(negedge core_clk);
      cfgWrEn = 0;
      cfgDone = 1;
      @(negedge core_clk);
      cfgDone = 0;
      done = 1;
      check(configuredFlag, 1);
      for (int i = 0; i < 8; i++) begin
        a = {baseA[i], 12'h0} + (32'h1000 << (i == 7 ? 12 : sizeA[i])) - 1;
        access({baseA[i], 12'h0});
        access(a);
        access(a + 1);
      end
    end
    give_verdict;
  end
endmodule : csd_chip_select_tb
